// File: verilog/cls_slice.v
// Configurable logic slice with APB register access.
// Assumes one 20 MHz clock pclk and asynchronous active-low presetn;
// neighbouring slices drive the chain inputs from the same clock.
//
// Behaviour
// R1 - Four modes: logic, ripple, RAM, ROM
// R2 - Four-input table holds sixteen output bits
// R3 - Two tables combine into five-input function
// R4 - Ripple: add, subtract, count up, down
// R5 - Ripple compares A, B: ge, ne, le
// R6 - Fast carry exports generate and propagate
// R7 - RAM: each table is 16x1 memory
// R8 - 16x2 single port one slice, dual two
// R9 - Companion slice gives independent read-only port
// R10 - ROM: no write port, loaded at configuration
// R11 - ROM mode gives 16x2 read-only memory
// R12 - RAM writes clocked, reads combinational
`timescale 1ns/1ps
`default_nettype none
`include "cls_defs.vh"

module cls_slice (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] lut_in0,
    input wire [3:0] lut_in1,
    input wire lut_sel,
    input wire ram_we,
    input wire [3:0] ram_waddr,
    input wire [1:0] ram_wdata,
    input wire [3:0] ram_raddr,
    input wire [3:0] companion_raddr,
    input wire carry_in,
    output reg [1:0] slice_out,
    output reg [1:0] companion_out,
    output reg carry_out,
    output reg carry_gen,
    output reg carry_prop,
    output reg cmp_ge,
    output reg cmp_ne,
    output reg cmp_le
);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    reg [6:0] ctrl_q; // Mode, op, fast carry, wide table, config window
    reg [15:0] tbl0_q; // Truth table of first four-input table
    reg [15:0] tbl1_q; // Truth table of second four-input table
    reg [4:0] oper_q; // Operands {cin, b, a}
    reg [1:0] cnt_q; // Counter state for up and down count

    // Decoded control fields
    wire [1:0] mode = ctrl_q[`CLS_CTRL_MODE_LO +: 2];
    wire [1:0] op_sel = ctrl_q[`CLS_CTRL_OP_LO +: 2];
    wire fast_carry = ctrl_q[`CLS_CTRL_FAST];
    wire wide_table = ctrl_q[`CLS_CTRL_WIDE];
    wire cfg_open = ctrl_q[`CLS_CTRL_CFG];

    // Register address match, shared by read and write paths
    function reg_hit;
        input [11:0] addr;
        input [11:0] offs;
        begin
            reg_hit = (addr == offs);
        end
    endfunction

    // Table lookup, one bit of a sixteen-entry truth table
    function tbl_pick;
        input [15:0] tbl;
        input [3:0] idx;
        begin
            tbl_pick = tbl[idx];
        end
    endfunction

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Zero wait states: pready follows the setup phase by one edge
    wire apb_access = psel & penable & pready;
    wire apb_wr = apb_access & pwrite;
    wire mapped = reg_hit(paddr, `CLS_REG_CTRL) | reg_hit(paddr, `CLS_REG_TBL0)
        | reg_hit(paddr, `CLS_REG_TBL1) | reg_hit(paddr, `CLS_REG_OPER)
        | reg_hit(paddr, `CLS_REG_RESULT) | reg_hit(paddr, `CLS_REG_ROMLD)
        | reg_hit(paddr, `CLS_REG_STATUS);

    // ROM preload goes through the config window only, never the fabric
    wire rom_ld = apb_wr & reg_hit(paddr, `CLS_REG_ROMLD) & cfg_open;

    // ----------------------------------------------------------------
    // Memory write steering
    // ----------------------------------------------------------------
    // The preload wins over a fabric write in the same cycle; both share
    // the one write port, so the fabric word is lost in that case
    // R8 - single-port write path
    // R10 - ROM blocks fabric writes
    wire mem_we = rom_ld | ((mode == `CLS_MODE_RAM) & ram_we);
    wire [3:0] mem_waddr = rom_ld ? pwdata[`CLS_ROMLD_ADDR_LO +: 4] : ram_waddr;
    wire [1:0] mem_wdata = rom_ld ? pwdata[`CLS_ROMLD_DATA_LO +: 2] : ram_wdata;
    wire [1:0] mem_rd_a;
    wire [1:0] mem_rd_b;

    // R7 - two 16x1 tables
    // R9 - companion read port
    cls_dist_mem #(
        .DEPTH(16),
        .AW(4),
        .DW(2)
    ) u_mem (
        .pclk(pclk),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr_a(ram_raddr),
        .rd_data_a(mem_rd_a),
        .rd_addr_b(companion_raddr),
        .rd_data_b(mem_rd_b)
    );

    // ----------------------------------------------------------------
    // Ripple unit
    // ----------------------------------------------------------------
    wire [1:0] rip_sum;
    wire rip_cout;
    wire rip_gen;
    wire rip_prop;
    wire rip_ge;
    wire rip_ne;
    wire rip_le;

    cls_ripple u_ripple (
        .op_sel(op_sel),
        .a(oper_q[1:0]),
        .b(oper_q[3:2]),
        .cin(oper_q[4] | carry_in),
        .cnt(cnt_q),
        .sum(rip_sum),
        .cout(rip_cout),
        .gen(rip_gen),
        .prop(rip_prop),
        .a_ge_b(rip_ge),
        .a_ne_b(rip_ne),
        .a_le_b(rip_le)
    );

    // ----------------------------------------------------------------
    // Logic mode tables
    // ----------------------------------------------------------------
    // R2 - sixteen-entry lookup
    wire lut_o0 = tbl_pick(tbl0_q, lut_in0);
    wire lut_o1 = tbl_pick(tbl1_q, lut_in1);
    // R3 - five-input combine
    // Fifth input steers between the tables sharing lut_in0
    wire wide_o = lut_sel ? tbl_pick(tbl1_q, lut_in0) : lut_o0;

    // ----------------------------------------------------------------
    // Mode output select
    // ----------------------------------------------------------------
    // R1 - mode selects output
    reg [1:0] slice_d;
    reg [1:0] comp_d;
    always @* begin
        comp_d = 2'h0;
        case (mode)
            `CLS_MODE_LOGIC: slice_d = wide_table ? {1'b0, wide_o} : {lut_o1, lut_o0};
            `CLS_MODE_RIPPLE: slice_d = (op_sel[1]) ? cnt_q : rip_sum;
            // R11 - ROM 16x2 read
            `CLS_MODE_RAM, `CLS_MODE_ROM: begin
                slice_d = mem_rd_a;
                comp_d = mem_rd_b;
            end
            default: slice_d = 2'h0;
        endcase
    end

    // Ripple side outputs only live in ripple mode
    wire rip_on = (mode == `CLS_MODE_RIPPLE);
    wire fast_on = rip_on & fast_carry;

    // Registered outputs; outputs must come straight from flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slice_out <= 2'h0;
            companion_out <= 2'h0;
            carry_out <= 1'b0;
            carry_gen <= 1'b0;
            carry_prop <= 1'b0;
            cmp_ge <= 1'b0;
            cmp_ne <= 1'b0;
            cmp_le <= 1'b0;
        end else begin
            slice_out <= slice_d;
            companion_out <= comp_d;
            carry_out <= rip_on & rip_cout;
            // R6 - carry terms exported
            carry_gen <= fast_on & rip_gen;
            carry_prop <= fast_on & rip_prop;
            // R5 - comparisons registered
            cmp_ge <= rip_on & rip_ge;
            cmp_ne <= rip_on & rip_ne;
            cmp_le <= rip_on & rip_le;
        end
    end

    // ----------------------------------------------------------------
    // Counter state
    // ----------------------------------------------------------------
    // R4 - counter steps
    // Counts every clock while a count op is selected in ripple mode
    // Wraps modulo four; the step's carry out of bit 1 still drives carry_out; chain through the
    // ripple add path when a wider count is wanted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `CLS_CNT_RST;
        end else if (rip_on & op_sel[1]) begin
            cnt_q <= rip_sum;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Writes to RESULT, STATUS or unmapped offsets change nothing here;
    // only the unmapped case is flagged, read-only offsets drop silently
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CLS_CTRL_RST;
            tbl0_q <= `CLS_TBL_RST;
            tbl1_q <= `CLS_TBL_RST;
            oper_q <= `CLS_OPER_RST;
        end else if (apb_wr) begin
            if (reg_hit(paddr, `CLS_REG_CTRL)) begin
                ctrl_q <= pwdata[6:0];
            end
            if (reg_hit(paddr, `CLS_REG_TBL0)) begin
                tbl0_q <= pwdata[15:0];
            end
            if (reg_hit(paddr, `CLS_REG_TBL1)) begin
                tbl1_q <= pwdata[15:0];
            end
            if (reg_hit(paddr, `CLS_REG_OPER)) begin
                oper_q <= pwdata[4:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // ROMLD reads back as zero: the preload path is write-only, so a
    // stuck loader cannot be seen from software
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = `CLS_RDATA_RST;
        if (reg_hit(paddr, `CLS_REG_CTRL)) begin
            rdata_d = {25'h0, ctrl_q};
        end else if (reg_hit(paddr, `CLS_REG_TBL0)) begin
            rdata_d = {16'h0, tbl0_q};
        end else if (reg_hit(paddr, `CLS_REG_TBL1)) begin
            rdata_d = {16'h0, tbl1_q};
        end else if (reg_hit(paddr, `CLS_REG_OPER)) begin
            rdata_d = {27'h0, oper_q};
        end else if (reg_hit(paddr, `CLS_REG_RESULT)) begin
            // Live datapath view: {le, ne, ge, prop, gen, cout, sum}
            rdata_d = {24'h0, rip_le, rip_ne, rip_ge, rip_prop, rip_gen,
                rip_cout, rip_sum};
        end else if (reg_hit(paddr, `CLS_REG_STATUS)) begin
            rdata_d = {26'h0, companion_out, slice_out, cnt_q};
        end
    end

    // APB answer: one wait-free access phase per transfer
    // Read data is captured at the setup edge, so a RESULT read shows the
    // datapath one cycle before pready; operands must be settled by then
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `CLS_RDATA_RST;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                prdata <= pwrite ? `CLS_RDATA_RST : rdata_d;
                // Unmapped offsets and ROM loads outside the window error
                pslverr <= ~mapped | (pwrite & reg_hit(paddr, `CLS_REG_ROMLD) & ~cfg_open);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/cls_defs.vh
// Constants for the configurable logic slice: mode codes, register map,
// field positions and reset values.
// Assumes inclusion by bare name from the slice design files.
`ifndef CLS_DEFS_VH
`define CLS_DEFS_VH

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define CLS_MODE_LOGIC 2'h0
`define CLS_MODE_RIPPLE 2'h1
`define CLS_MODE_RAM 2'h2
`define CLS_MODE_ROM 2'h3

// ----------------------------------------------------------------
// Ripple operation selects
// ----------------------------------------------------------------
`define CLS_OP_ADD 2'h0
`define CLS_OP_SUB 2'h1
`define CLS_OP_UP 2'h2
`define CLS_OP_DOWN 2'h3

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CLS_REG_CTRL 12'h000
`define CLS_REG_TBL0 12'h004
`define CLS_REG_TBL1 12'h008
`define CLS_REG_OPER 12'h00C
`define CLS_REG_RESULT 12'h010
`define CLS_REG_ROMLD 12'h014
`define CLS_REG_STATUS 12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CLS_CTRL_MODE_LO 0
`define CLS_CTRL_OP_LO 2
`define CLS_CTRL_FAST 4
`define CLS_CTRL_WIDE 5
`define CLS_CTRL_CFG 6
`define CLS_ROMLD_DATA_LO 0
`define CLS_ROMLD_ADDR_LO 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CLS_CTRL_RST 7'h00
`define CLS_TBL_RST 16'h0000
`define CLS_OPER_RST 5'h00
`define CLS_CNT_RST 2'h0
`define CLS_RDATA_RST 32'h00000000

`endif

// File: verilog/cls_dist_mem.v
// Distributed memory: two four-input tables, each 16 words by 1 bit,
// forming one 16x2 array with a write port and two read ports.
// Assumes the caller gates writes by mode; reads are combinational.
`timescale 1ns/1ps
`default_nettype none

module cls_dist_mem #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter DW = 2
) (
    input wire pclk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr_a,
    output wire [DW-1:0] rd_data_a,
    input wire [AW-1:0] rd_addr_b,
    output wire [DW-1:0] rd_data_b
);

    // Storage; no reset, as in a real fabric table
    reg [DW-1:0] mem [0:DEPTH-1];

    // ----------------------------------------------------------------
    // Write port
    // ----------------------------------------------------------------
    // R12 - clocked write
    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // R12 - combinational reads
    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];

endmodule

`default_nettype wire

// File: verilog/cls_ripple.v
// Two-bit ripple arithmetic unit with comparator and carry terms.
// Assumes operands come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cls_defs.vh"

module cls_ripple (
    input wire [1:0] op_sel,
    input wire [1:0] a,
    input wire [1:0] b,
    input wire cin,
    input wire [1:0] cnt,
    output reg [1:0] sum,
    output reg cout,
    output wire gen,
    output wire prop,
    output wire a_ge_b,
    output wire a_ne_b,
    output wire a_le_b
);

    // Extended result including carry
    reg [2:0] ext;

    // ----------------------------------------------------------------
    // Arithmetic select
    // ----------------------------------------------------------------
    // R4 - add sub count
    always @* begin
        case (op_sel)
            `CLS_OP_ADD: ext = {1'b0, a} + {1'b0, b} + {2'h0, cin};
            // Subtract as a plus not b plus carry-in, borrow is not cout
            `CLS_OP_SUB: ext = {1'b0, a} + {1'b0, ~b} + {2'h0, cin};
            `CLS_OP_UP: ext = {1'b0, cnt} + 3'h1;
            `CLS_OP_DOWN: ext = {1'b0, cnt} + 3'h3;
            default: ext = 3'h0;
        endcase
        sum = ext[1:0];
        cout = ext[2];
    end

    // R6 - generate and propagate
    // Group terms across both bits so the next slice skips the ripple
    wire [1:0] bb = (op_sel == `CLS_OP_SUB) ? ~b : b;
    wire [1:0] g = a & bb;
    wire [1:0] p = a ^ bb;
    assign gen = g[1] | (p[1] & g[0]);
    assign prop = p[1] & p[0];

    // R5 - comparator outputs
    assign a_ge_b = (a >= b);
    assign a_ne_b = (a != b);
    assign a_le_b = (a <= b);

endmodule

`default_nettype wire

// File: dv/cls_slice_chk.sv
// Checker: port-level properties of the logic slice.
// Assumes a bind to cls_slice; CTRL is shadowed by snooping APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "cls_defs.vh"
module cls_slice_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire ram_we,
    input wire [3:0] ram_waddr,
    input wire [1:0] ram_wdata,
    input wire [3:0] ram_raddr,
    input wire [1:0] slice_out,
    input wire carry_out,
    input wire carry_gen,
    input wire carry_prop,
    input wire cmp_ge,
    input wire cmp_ne,
    input wire cmp_le
);
// ------------------------------------------------
// Shadow of CTRL and cycles since its last write
// ------------------------------------------------
reg [6:0] ctrl_q; // Last written CTRL value
reg [1:0] age_q; // Saturates at 3: outputs then reflect the mode
wire wr_ctrl = psel && penable && pready && pwrite && paddr == `CLS_REG_CTRL;
wire settled = age_q == 2'h3;
wire [1:0] mode = ctrl_q[1:0];
wire [1:0] op = ctrl_q[3:2];
// Track writes; age guards against judging the mode switch itself
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_q <= 7'h00;
        age_q <= 2'h0;
    end else if (wr_ctrl) begin
        ctrl_q <= pwdata[6:0];
        age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
        age_q <= age_q + 2'h1;
    end
end
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// ------------------------------------------------
// Properties
// ------------------------------------------------
AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
AST_RIPPLE_ONLY: assert property (settled && mode != `CLS_MODE_RIPPLE |->
    {carry_out, carry_gen, carry_prop, cmp_ge, cmp_ne, cmp_le} == 6'h00)
    else $error("arithmetic outputs active outside ripple");
AST_FAST_ONLY: assert property (settled && !ctrl_q[4] |-> !carry_gen && !carry_prop)
    else $error("generate or propagate without fast carry");
AST_CMP_CONSIST: assert property (settled && mode == `CLS_MODE_RIPPLE |->
    (cmp_ge || cmp_le) && cmp_ne == !(cmp_ge && cmp_le))
    else $error("comparison flags inconsistent");
AST_COUNT_UP: assert property (settled && mode == `CLS_MODE_RIPPLE && op == `CLS_OP_UP
    |=> slice_out == $past(slice_out) + 2'h1)
    else $error("up counter did not step");
AST_COUNT_DOWN: assert property (settled && mode == `CLS_MODE_RIPPLE && op == `CLS_OP_DOWN
    |=> slice_out == $past(slice_out) - 2'h1)
    else $error("down counter did not step");
AST_RAM_RDW: assert property (settled && mode == `CLS_MODE_RAM && ram_we &&
    ram_waddr == ram_raddr ##1 $stable(ram_raddr) |=> slice_out == $past(ram_wdata, 2))
    else $error("written word not read back");
AST_ROM_HOLD: assert property ((settled && mode == `CLS_MODE_ROM && !psel &&
    $stable(ram_raddr)) [*3] |-> $stable(slice_out))
    else $error("read-only contents changed");
cover property (settled && mode == `CLS_MODE_RIPPLE && op == `CLS_OP_UP);
cover property (settled && mode == `CLS_MODE_RAM && ram_we);
cover property (pslverr);
endmodule
`default_nettype wire

// File: dv/cls_nbr.sv
// Neighbouring slice: feeds the carry chain input of the slice.
// Assumes the shared fabric clock; its carry is a registered output.
`timescale 1ns/1ps
`default_nettype none
module cls_nbr (
    input wire pclk,
    input wire presetn,
    input wire carry_req,
    output reg carry_in
);
// A real neighbour changes its carry only after a clock edge
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        carry_in <= 1'b0;
    end else begin
        carry_in <= carry_req;
    end
end
endmodule
`default_nettype wire

// File: dv/cls_slice_tb_top.sv
// Testbench top for the logic slice: APB tasks and fabric stimulus.
// Assumes the cls_defs.vh constants and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
`include "cls_defs.vh"
module cls_slice_tb_top;
localparam [15:0] T0 = 16'hA5C3; // Table 0 pattern
localparam [15:0] T1 = 16'h3C96; // Table 1 pattern
reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
reg lut_sel = 1'b0, ram_we = 1'b0, carry_req = 1'b0, er;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, rd;
reg [3:0] lut_in0 = 4'h0, lut_in1 = 4'h0, ram_waddr = 4'h0, ram_raddr = 4'h0;
reg [3:0] companion_raddr = 4'h0;
reg [1:0] ram_wdata = 2'h0, a, b, bb, g, p;
reg [2:0] s;
reg [7:0] x;
wire [31:0] prdata;
wire pready, pslverr, carry_in, carry_out, carry_gen, carry_prop, cmp_ge, cmp_ne, cmp_le;
wire [1:0] slice_out, companion_out;
int mismatches = 0, compares = 0, i, f, o;
// 20 MHz clock
always #25 pclk = ~pclk;
cls_nbr nbr (.pclk(pclk), .presetn(presetn), .carry_req(carry_req), .carry_in(carry_in));
cls_slice dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lut_in0(lut_in0), .lut_in1(lut_in1), .lut_sel(lut_sel),
    .ram_we(ram_we), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata), .ram_raddr(ram_raddr),
    .companion_raddr(companion_raddr), .carry_in(carry_in), .slice_out(slice_out),
    .companion_out(companion_out), .carry_out(carry_out), .carry_gen(carry_gen),
    .carry_prop(carry_prop), .cmp_ge(cmp_ge), .cmp_ne(cmp_ne), .cmp_le(cmp_le));
// ------------------------------------------------
// Tasks
// ------------------------------------------------
task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task check(input string what, input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
        mismatches++;
        $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
endtask
// One APB transfer; request held until pready is sampled high
task apb(input w, input [11:0] ad, input [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
        @(posedge pclk);
        if (pready === 1'b1) break;
    end
    if (n < 16) begin
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end else begin
        mismatches++;
        stop_test;
    end
endtask
// ------------------------------------------------
// Main sequence
// ------------------------------------------------
initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CLS_REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h01C, 32'h0);
    check("unmapped err", 32'(er), 32'h1);
    apb(1'b1, `CLS_REG_TBL0, 32'(T0));
    apb(1'b1, `CLS_REG_TBL1, 32'(T1));
    apb(1'b0, `CLS_REG_TBL0, 32'h0);
    check("tbl0 read", rd, 32'(T0));
    for (i = 0; i < 16; i++) begin
        @(posedge pclk);
        lut_in0 <= i[3:0];
        lut_in1 <= ~i[3:0];
        @(posedge pclk);
        #1;
        check("four_input_table", 32'(slice_out), 32'({T1[~i[3:0]], T0[i[3:0]]}));
    end
    apb(1'b1, `CLS_REG_CTRL, 32'h20);
    for (i = 0; i < 32; i++) begin
        @(posedge pclk);
        lut_in0 <= i[3:0];
        lut_sel <= i[4];
        @(posedge pclk);
        #1;
        check("five_input_table", 32'(slice_out), 32'(i[4] ? T1[i[3:0]] : T0[i[3:0]]));
    end
    $display("test logic done");
    // Ripple add and subtract, with and without fast carry
    for (f = 0; f < 2; f++) begin
        for (o = 0; o < 2; o++) begin
            apb(1'b1, `CLS_REG_CTRL, 32'(f * 16 + o * 4 + 1));
            for (i = 0; i < 32; i++) begin
                @(posedge pclk);
                carry_req <= f[0] & i[4];
                apb(1'b1, `CLS_REG_OPER, 32'(f ? i % 16 : i));
                repeat (2) @(posedge pclk);
                apb(1'b0, `CLS_REG_RESULT, 32'h0);
                a = i[1:0];
                b = i[3:2];
                bb = o ? ~b : b;
                s = a + bb + i[4];
                g = a & bb;
                p = a ^ bb;
                x = {a <= b, a != b, a >= b, &p, g[1] | p[1] & g[0], s};
                check("result", rd, 32'(x));
                check("gen", 32'(carry_gen), 32'(f[0] & x[3]));
                check("prop", 32'(carry_prop), 32'(f[0] & x[4]));
                check("cmp", 32'({cmp_le, cmp_ne, cmp_ge, carry_out}), 32'({x[7:5], x[2]}));
            end
        end
    end
    carry_req <= 1'b0;
    // Counters step once a clock
    for (o = 2; o < 4; o++) begin
        apb(1'b1, `CLS_REG_CTRL, 32'(o * 4 + 1));
        repeat (3) @(posedge pclk);
        #1;
        x = 8'(slice_out);
        for (i = 1; i < 5; i++) begin
            @(posedge pclk);
            #1;
            check("count", 32'(slice_out), 32'(2'(o == 2 ? x + i : x - i)));
        end
    end
    $display("test ripple done");
    // RAM: fill all words, read both ports
    apb(1'b1, `CLS_REG_CTRL, 32'h2);
    for (i = 0; i < 16; i++) begin
        @(posedge pclk);
        ram_we <= 1'b1;
        ram_waddr <= i[3:0];
        ram_wdata <= i[1:0] ^ i[3:2];
    end
    @(posedge pclk);
    ram_we <= 1'b0;
    for (i = 0; i < 16; i++) begin
        @(posedge pclk);
        ram_raddr <= i[3:0];
        companion_raddr <= ~i[3:0];
        @(posedge pclk);
        #1;
        check("ram a", 32'(slice_out), 32'(i[1:0] ^ i[3:2]));
        check("ram b", 32'(companion_out), 32'(~i[1:0] ^ ~i[3:2]));
    end
    @(posedge pclk);
    ram_we <= 1'b1;
    ram_waddr <= 4'h5;
    ram_raddr <= 4'h5;
    ram_wdata <= 2'h2;
    @(posedge pclk);
    ram_we <= 1'b0;
    @(posedge pclk);
    #1;
    check("ram rdw", 32'(slice_out), 32'h2);
    $display("test ram done");
    // ROM: load only in the configuration window, fabric writes ignored
    apb(1'b1, `CLS_REG_ROMLD, 32'h00000301);
    check("romld refused", 32'(er), 32'h1);
    @(posedge pclk);
    ram_raddr <= 4'h3;
    repeat (2) @(posedge pclk);
    #1;
    check("romld no write", 32'(slice_out), 32'h3);
    apb(1'b1, `CLS_REG_CTRL, 32'h43);
    apb(1'b1, `CLS_REG_ROMLD, 32'h00000301);
    check("romld ok", 32'(er), 32'h0);
    @(posedge pclk);
    ram_we <= 1'b1;
    ram_waddr <= 4'h3;
    ram_wdata <= 2'h2;
    ram_raddr <= 4'h3;
    companion_raddr <= 4'h3;
    @(posedge pclk);
    ram_we <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    check("rom a", 32'(slice_out), 32'h1);
    check("rom b", 32'(companion_out), 32'h1);
    apb(1'b0, `CLS_REG_STATUS, 32'h0);
    check("status", 32'(rd[5:2]), 32'h5);
    $display("test rom done");
    stop_test;
end
endmodule
bind cls_slice cls_slice_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ram_we(ram_we), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata),
    .ram_raddr(ram_raddr), .slice_out(slice_out), .carry_out(carry_out),
    .carry_gen(carry_gen), .carry_prop(carry_prop), .cmp_ge(cmp_ge), .cmp_ne(cmp_ne),
    .cmp_le(cmp_le));
`default_nettype wire
